// file: rtl/srcx_top.v
// Purpose: setpoint relays, settings and hour counters of a vacuum gauge controller
// Assumes: pressures arrive as log codes synchronous to clk; settings over AXI4-Lite
// Notes:   rejected setpoint writes answer SLVERR and keep the old value
`timescale 1ns/1ps
`include "srcx_defines.vh"

module srcx_top #(
  parameter CYC_PER_SEC  = `SRCX_CYC_PER_SEC,
  parameter SEC_PER_HOUR = `SRCX_SEC_PER_HOUR
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // measurement chain
  input  wire [15:0] ionization_sensor_pressure,
  input  wire [15:0] convection_gauge_one_pressure,
  input  wire [15:0] convection_gauge_two_pressure,
  input  wire        filament_on,
  input  wire        degas_on,
  // relay drives
  output reg         ion_relay,
  output reg         first_conv_relay,
  output reg         second_conv_relay,
  // settings to the rest of the controller
  output reg         filament_sel,
  output reg         ion_aout_mode,
  output reg         cg1_aout_type,
  output reg         cg2_aout_type,
  output reg  [7:0]  station_addr,
  output reg  [2:0]  baud_sel
);

  // ========================================================================
  // reset synchroniser
  reg rst_meta_q;
  reg rst_sync_b_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q   <= 1'b0;
      rst_sync_b_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_b_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // helpers
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wmerge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // a setpoint edit passes when inside limits and ordered against its partner
  function sp_ok;
    input [15:0] val;
    input [15:0] vmin;
    input [15:0] vmax;
    input        is_high;
    input [15:0] partner;
    begin
      sp_ok = (val >= vmin) && (val <= vmax) &&
              (is_high ? (val >= partner) : (val <= partner));
    end
  endfunction

  // ========================================================================
  // registers
  reg [15:0] sp_q [0:5];
  reg [31:0] ctrl_q;
  reg [15:0] fil_hours_q [0:1];
  reg [15:0] deg_hours_q [0:1];
  reg        last_rej_q;

  reg [7:0]  aw_addr_q;
  reg        aw_held_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        w_held_q;

  wire       do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [2:0] sp_idx   = aw_addr_q[4:2];
  wire       sp_sel   = (aw_addr_q <= `SRCX_OFS_B_HI) && (aw_addr_q[1:0] == 2'b00);
  wire [31:0] sp_new  = wmerge({16'h0000, sp_q[sp_idx[2:0]]}, w_data_q, w_strb_q);
  wire [2:0] sp_pair  = {sp_idx[2:1], ~sp_idx[0]};
  wire       sp_conv  = (sp_idx != 3'd0) && (sp_idx != 3'd1);
  wire       sp_pass  = sp_ok(sp_new[15:0],
                              sp_conv ? `SRCX_CONV_MIN : `SRCX_ION_MIN,
                              sp_conv ? `SRCX_CONV_MAX : `SRCX_ION_MAX,
                              sp_idx[0], sp_q[sp_pair]);

  // ========================================================================
  // write channel
  always @(posedge clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      aw_addr_q     <= 8'h00;
      aw_held_q     <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SRCX_RESP_OKAY;
      sp_q[0]       <= `SRCX_ION_LO_RST;
      sp_q[1]       <= `SRCX_ION_HI_RST;
      sp_q[2]       <= `SRCX_CONV_A_LO_RST;
      sp_q[3]       <= `SRCX_CONV_A_HI_RST;
      sp_q[4]       <= `SRCX_CONV_B_LO_RST;
      sp_q[5]       <= `SRCX_CONV_B_HI_RST;
      ctrl_q        <= `SRCX_CTRL_RST;
      last_rej_q    <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SRCX_RESP_OKAY;
        if (sp_sel) begin
          if (sp_pass) begin
            sp_q[sp_idx] <= sp_new[15:0];
            last_rej_q   <= 1'b0;
          end else begin
            last_rej_q   <= 1'b1;
            s_axi_bresp  <= `SRCX_RESP_SLVERR;
          end
        end else if (aw_addr_q == `SRCX_OFS_CTRL) begin
          ctrl_q <= wmerge(ctrl_q, w_data_q, w_strb_q) & `SRCX_CTRL_MASK;
        end else if (aw_addr_q == `SRCX_OFS_STATUS ||
                     aw_addr_q == `SRCX_OFS_FIL_HOURS ||
                     aw_addr_q == `SRCX_OFS_DEG_HOURS) begin
          s_axi_bresp <= `SRCX_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SRCX_RESP_SLVERR;
        end
      end
    end
  end

  // ========================================================================
  // relays with hysteresis
  reg  [2:0]  relay_q;
  wire [15:0] a_press = ctrl_q[`SRCX_CTRL_A_SRC] ? convection_gauge_two_pressure
                                                 : convection_gauge_one_pressure;
  wire [15:0] b_press = ctrl_q[`SRCX_CTRL_B_SRC] ? convection_gauge_two_pressure
                                                 : convection_gauge_one_pressure;
  wire [47:0] press_all = {b_press, a_press, ionization_sensor_pressure};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_relay
      always @(posedge clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
          relay_q[g] <= 1'b0;
        end else if (press_all[g*16 +: 16] < sp_q[2*g]) begin
          relay_q[g] <= 1'b1;
        end else if (press_all[g*16 +: 16] > sp_q[2*g+1]) begin
          relay_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================================
  // outputs, all from flip-flops
  wire [2:0] test_en  = ctrl_q[`SRCX_CTRL_TEST_LSB +: 3];
  wire [2:0] test_val = ctrl_q[`SRCX_CTRL_FORCE_LSB +: 3];
  wire [2:0] relay_d  = (relay_q & ~test_en) | (test_val & test_en);

  always @(posedge clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      ion_relay         <= 1'b0;
      first_conv_relay  <= 1'b0;
      second_conv_relay <= 1'b0;
      filament_sel      <= 1'b0;
      ion_aout_mode     <= 1'b0;
      cg1_aout_type     <= 1'b0;
      cg2_aout_type     <= 1'b0;
      station_addr      <= 8'h00;
      baud_sel          <= `SRCX_BAUD_19200;
    end else begin
      ion_relay         <= relay_d[0];
      first_conv_relay  <= relay_d[1];
      second_conv_relay <= relay_d[2];
      filament_sel      <= ctrl_q[`SRCX_CTRL_FIL_SEL];
      ion_aout_mode     <= ctrl_q[`SRCX_CTRL_ION_MODE];
      cg1_aout_type     <= ctrl_q[`SRCX_CTRL_CG1_TYPE];
      cg2_aout_type     <= ctrl_q[`SRCX_CTRL_CG2_TYPE];
      station_addr      <= {ctrl_q[`SRCX_CTRL_OFS_LSB +: 4],
                            ctrl_q[`SRCX_CTRL_ADDR_LSB +: 4]};
      baud_sel          <= ctrl_q[`SRCX_CTRL_BAUD_LSB +: 3];
    end
  end

  // ========================================================================
  // hour counters: timer 0 counts filament time, timer 1 degas time while the filament is on
  wire [1:0]  tmr_run = {degas_on & filament_on, filament_on};
  reg  [31:0] sec_cnt_q [0:1];
  reg  [11:0] hr_cnt_q  [0:1];
  wire [1:0]  hr_tick;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_timer
      assign hr_tick[g] = tmr_run[g] && (sec_cnt_q[g] == CYC_PER_SEC - 1) &&
                          (hr_cnt_q[g] == SEC_PER_HOUR - 1);
      always @(posedge clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
          sec_cnt_q[g] <= 32'h00000000;
          hr_cnt_q[g]  <= 12'h000;
        end else if (tmr_run[g]) begin
          if (sec_cnt_q[g] == CYC_PER_SEC - 1) begin
            sec_cnt_q[g] <= 32'h00000000;
            if (hr_cnt_q[g] == SEC_PER_HOUR - 1) begin
              hr_cnt_q[g] <= 12'h000;
            end else begin
              hr_cnt_q[g] <= hr_cnt_q[g] + 12'h001;
            end
          end else begin
            sec_cnt_q[g] <= sec_cnt_q[g] + 32'h00000001;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      fil_hours_q[0] <= 16'h0000;
      fil_hours_q[1] <= 16'h0000;
      deg_hours_q[0] <= 16'h0000;
      deg_hours_q[1] <= 16'h0000;
    end else begin
      if (hr_tick[0]) begin
        fil_hours_q[filament_sel] <= fil_hours_q[filament_sel] + 16'h0001;
      end
      if (hr_tick[1]) begin
        deg_hours_q[filament_sel] <= deg_hours_q[filament_sel] + 16'h0001;
      end
    end
  end

  // ========================================================================
  // read channel
  reg [31:0] rd_d;
  reg        rd_err;

  always @* begin
    rd_d   = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr <= `SRCX_OFS_B_HI && s_axi_araddr[1:0] == 2'b00) begin
      rd_d = {16'h0000, sp_q[s_axi_araddr[4:2]]};
    end else if (s_axi_araddr == `SRCX_OFS_CTRL) begin
      rd_d = ctrl_q;
    end else if (s_axi_araddr == `SRCX_OFS_STATUS) begin
      rd_d = {16'h0000, station_addr, 4'h0, last_rej_q,
              second_conv_relay, first_conv_relay, ion_relay};
    end else if (s_axi_araddr == `SRCX_OFS_FIL_HOURS) begin
      rd_d = {fil_hours_q[1], fil_hours_q[0]};
    end else if (s_axi_araddr == `SRCX_OFS_DEG_HOURS) begin
      rd_d = {deg_hours_q[1], deg_hours_q[0]};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SRCX_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= rd_err ? `SRCX_RESP_SLVERR : `SRCX_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // srcx_top

// file: rtl/srcx_defines.vh
// Purpose: constants of the setpoint relay and settings block
// Assumes: pressure code = 1000 * (log10(P in Torr) + 12), 16 bits unsigned
// Notes:   byte offsets of the register map of the AXI4-Lite slave
`ifndef SRCX_DEFINES_VH
`define SRCX_DEFINES_VH

// ==========================================================================
// register byte offsets
`define SRCX_OFS_ION_LO      8'h00
`define SRCX_OFS_ION_HI      8'h04
`define SRCX_OFS_A_LO        8'h08
`define SRCX_OFS_A_HI        8'h0c
`define SRCX_OFS_B_LO        8'h10
`define SRCX_OFS_B_HI        8'h14
`define SRCX_OFS_CTRL        8'h18
`define SRCX_OFS_STATUS      8'h1c
`define SRCX_OFS_FIL_HOURS   8'h20
`define SRCX_OFS_DEG_HOURS   8'h24

// ==========================================================================
// setpoint codes (1000 per decade, 0 = 1.0E-12 Torr)
`define SRCX_ION_LO_RST      16'h1770
`define SRCX_ION_HI_RST      16'h1a2b
`define SRCX_ION_MIN         16'h03e8
`define SRCX_ION_MAX         16'h28ed
`define SRCX_CONV_A_LO_RST   16'h2af8
`define SRCX_CONV_A_HI_RST   16'h2c25
`define SRCX_CONV_B_LO_RST   16'h2af8
`define SRCX_CONV_B_HI_RST   16'h2c25
`define SRCX_CONV_MIN        16'h2328
`define SRCX_CONV_MAX        16'h3a98

// ==========================================================================
// control register fields
`define SRCX_CTRL_A_SRC      0
`define SRCX_CTRL_B_SRC      1
`define SRCX_CTRL_FIL_SEL    2
`define SRCX_CTRL_ION_MODE   3
`define SRCX_CTRL_CG1_TYPE   4
`define SRCX_CTRL_CG2_TYPE   5
`define SRCX_CTRL_TEST_LSB   8
`define SRCX_CTRL_FORCE_LSB  12
`define SRCX_CTRL_ADDR_LSB   16
`define SRCX_CTRL_OFS_LSB    20
`define SRCX_CTRL_BAUD_LSB   24
`define SRCX_CTRL_MASK       32'h07ff773f
`define SRCX_CTRL_RST        32'h02010002
`define SRCX_BAUD_19200      3'h2

// ==========================================================================
// axi responses and hour time base
`define SRCX_RESP_OKAY       2'b00
`define SRCX_RESP_SLVERR     2'b10
`define SRCX_CYC_PER_SEC     40000000
`define SRCX_SEC_PER_HOUR    3600

`endif

// file: tb/srcx_sva.sv
// Purpose: bus and settings checks on the ports of srcx_top
// Assumes: bound into every srcx_top instance
// Notes:   rejected or unmapped accesses answer SLVERR
`timescale 1ns/1ps
`include "srcx_defines.vh"
module srcx_sva (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  // write channels
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // settings
  input wire [2:0]  baud_sel,
  input wire        filament_sel,
  input wire        ion_aout_mode
);
  // ==========================================================================
  // sequences
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wbad_s;
    s_axi_awaddr > 8'h24 ##0 wr_s;
  endsequence
  sequence rd_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================================
  // properties
  write_answer_a: assert property (wr_s |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  bad_write_a: assert property (wbad_s |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  ready_drop_a: assert property (wr_s |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready stays high");
  read_answer_a: assert property (rd_s |=> s_axi_rvalid)
    else $error("read not answered");
  bad_read_a: assert property (rd_s ##0 s_axi_araddr > 8'h24 |=> s_axi_rresp == 2'b10
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  set_change_a: assert property (!$stable({baud_sel, filament_sel, ion_aout_mode}) |->
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("setting changed without write");
endmodule // srcx_sva

bind srcx_top srcx_sva i_srcx_sva (
  .clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .baud_sel(baud_sel), .filament_sel(filament_sel),
  .ion_aout_mode(ion_aout_mode));

// file: tb/srcx_gauge_model.sv
// Purpose: measurement chain feeding the relay block
// Assumes: targets set by the bench just after a rising edge
// Notes:   one register stage, like a sampled gauge reading
`timescale 1ns/1ps
module srcx_gauge_model (
  // clock and targets
  input wire        clk,
  input wire [15:0] ion_t,
  input wire [15:0] g1_t,
  input wire [15:0] g2_t,
  input wire        fil_t,
  input wire        deg_t,
  // readings
  output reg [15:0] ion_p = 16'h3a98,
  output reg [15:0] g1_p = 16'h3a98,
  output reg [15:0] g2_p = 16'h3a98,
  output reg        fil_p = 1'b0,
  output reg        deg_p = 1'b0
);
  always @(posedge clk) begin
    ion_p <= ion_t;
    g1_p <= g1_t;
    g2_p <= g2_t;
    fil_p <= fil_t;
    deg_p <= deg_t;
  end
endmodule // srcx_gauge_model

// file: tb/tb_top.sv
// Purpose: self-checking bench of srcx_top
// Assumes: hour time base shortened to 12 cycles
// Notes:   expectations come from bench functions
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, st;
  logic [31:0] wdata = 0, rdata, v, c;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, fil_p, deg_p, ion_r, a_r, b_r;
  logic        fil_s, mode_s, t1, t2, asrc, bsrc, fil_t = 0, deg_t = 0;
  logic [15:0] ion_t = 16'h3a98, g1_t = 16'h3a98, g2_t = 16'h3a98, ion_p, g1_p, g2_p;
  logic [15:0] sp [6];
  logic [2:0]  baud, rly;
  logic [31:0] rv [10] = '{32'h1770, 32'h1a2b, 32'h2af8, 32'h2c25, 32'h2af8, 32'h2c25,
                           32'h02010002, 32'h100, 32'h0, 32'h0};
  int          ci [10] = '{0, 1, 0, 0, 1, 1, 2, 3, 3, 4};
  logic [15:0] cx [10] = '{16'h1b58, 16'h176f, 16'h03e7, 16'h03e8, 16'h28ed, 16'h28ee,
                           16'h2327, 16'h3a98, 16'h3a99, 16'h2c26};
  int          mismatches = 0, cmp_count = 0, j;
  always #12.5 clk = ~clk;
  // ==========================================================================
  // design and measurement chain
  srcx_top #(.CYC_PER_SEC(4), .SEC_PER_HOUR(3)) i_srcx_top (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ionization_sensor_pressure(ion_p), .convection_gauge_one_pressure(g1_p),
    .convection_gauge_two_pressure(g2_p), .filament_on(fil_p), .degas_on(deg_p),
    .ion_relay(ion_r), .first_conv_relay(a_r), .second_conv_relay(b_r), .filament_sel(fil_s),
    .ion_aout_mode(mode_s), .cg1_aout_type(t1), .cg2_aout_type(t2), .station_addr(st),
    .baud_sel(baud));
  srcx_gauge_model i_srcx_gauge_model (.clk(clk), .ion_t(ion_t), .g1_t(g1_t), .g2_t(g2_t),
    .fil_t(fil_t), .deg_t(deg_t), .ion_p(ion_p), .g1_p(g1_p), .g2_p(g2_p), .fil_p(fil_p),
    .deg_p(deg_p));
  // ==========================================================================
  // tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, da, dw;
    da = 0;
    dw = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      da |= ta;
      dw |= tw;
    end
    repeat ($urandom % 3) @(posedge clk);
    bready <= 1;
    do begin
      @(negedge clk);
      ta = bvalid;
      r = bresp;
      @(posedge clk);
    end while (!ta);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    bit t;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 0;
    repeat ($urandom % 3) @(posedge clk);
    rready <= 1;
    do begin
      @(negedge clk);
      t = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
    end while (!t);
    rready <= 0;
  endtask
  function logic hy(logic p, logic [15:0] x, logic [15:0] lo, logic [15:0] hi);
    return x < lo ? 1'b1 : x > hi ? 1'b0 : p;
  endfunction
  task look(input logic [2:0] e);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("relays", 32'(e), 32'({ion_r, a_r, b_r}));
    @(posedge clk);
  endtask
  task step(input logic [15:0] i, input logic [15:0] g1, input logic [15:0] g2);
    ion_t <= i;
    g1_t <= g1;
    g2_t <= g2;
    rly = {hy(rly[2], i, sp[0], sp[1]), hy(rly[1], asrc ? g2 : g1, sp[2], sp[3]),
           hy(rly[0], bsrc ? g2 : g1, sp[4], sp[5])};
    look(rly);
  endtask
  task spw(input int i, input logic [15:0] x);
    logic ok;
    ok = (i < 2 ? x >= 16'h03e8 && x <= 16'h28ed : x >= 16'h2328 && x <= 16'h3a98)
         && (i[0] ? x >= sp[i-1] : x <= sp[i+1]);
    wr(8'(i * 4), {16'h0, x});
    chk("set resp", ok ? 32'h0 : 32'h2, 32'(r));
    if (ok) sp[i] = x;
    rd(8'(i * 4));
    chk("set value", 32'(sp[i]), v);
    rd(8'h1c);
    chk("reject flag", 32'(!ok), 32'(v[3]));
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    #(25 * 40000);
    mismatches++;
    results;
  end
  initial begin
    void'($urandom(25987));
    sp = '{16'h1770, 16'h1a2b, 16'h2af8, 16'h2c25, 16'h2af8, 16'h2c25};
    {rly, asrc, bsrc} = 5'b00001;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4));
      chk("reset word", rv[i], v);
    end
    chk("reset outputs", 32'h0102, {st, 5'h0, baud});
    $display("test reset done");
    step(16'h1388, 16'h2710, 16'h2ee0);
    step(16'h1964, 16'h2b5c, 16'h2b5c);
    step(16'h1b58, 16'h2ee0, 16'h2710);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        wr(8'h18, 32'h02010001);
        {asrc, bsrc} = 2'b10;
        step(ion_t, g1_t, g2_t);
      end
      step(16'h1500 + 16'($urandom % 2048), 16'h2a80 + 16'($urandom % 640),
           16'h2a80 + 16'($urandom % 640));
    end
    wr(8'h18, 32'h02017702);
    look(3'h7);
    wr(8'h18, 32'h02010702);
    look(3'h0);
    wr(8'h18, 32'h02010002);
    $display("test relays done");
    for (int i = 0; i < 10; i++) spw(ci[i], cx[i]);
    for (int i = 0; i < 8; i++) begin
      j = $urandom % 6;
      spw(j, j < 2 ? 16'h0380 + 16'($urandom % 10240) : 16'h2300 + 16'($urandom % 6400));
    end
    $display("test setpoints done");
    for (int i = 0; i < 8; i++) begin
      c = i == 0 ? 32'h000f0000 : i == 1 ? 32'h00500000 : $urandom;
      wr(8'h18, c);
      rd(8'h18);
      chk("ctrl", c & 32'h07ff773f, v);
      chk("station", {24'h0, c[23:16]}, {24'h0, st});
      chk("modes", {c[26:24], c[5:2]}, {baud, t2, t1, mode_s, fil_s});
    end
    wr(8'h18, 32'h02010002);
    $display("test settings done");
    fil_t <= 1;
    deg_t <= 1;
    repeat (30) @(posedge clk);
    fil_t <= 0;
    deg_t <= 0;
    wr(8'h18, 32'h02010006);
    fil_t <= 1;
    repeat (26) @(posedge clk);
    fil_t <= 0;
    repeat (4) @(posedge clk);
    rd(8'h20);
    chk("filament hours", 32'h00020002, v);
    rd(8'h24);
    chk("degas hours", 32'h00000002, v);
    $display("test hours done");
    rd(8'h28);
    chk("unmapped read", 32'h2, 32'(r));
    chk("unmapped data", 32'h0, v);
    wr(8'h28, $urandom);
    chk("unmapped write", 32'h2, 32'(r));
    wr(8'h1c, 32'h0);
    chk("read-only write", 32'h0, 32'(r));
    $display("test bus done");
    results;
  end
endmodule // tb_top
